// file: src/psm_regs.sv
`timescale 1ns/1ps
module psm_regs
   import psm_pkg::*;
#(
   parameter logic [3:0] REV_CODE = 4'h3 // arbitrary value
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // register access
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [10:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   // straps, levels captured at reset release
   input wire psm_strap_t strap_a_i,
   input wire logic strap_managed_i,
   // pads
   input wire logic [15:0] pad_level_i,
   input wire logic pad_force_i,
   output logic [15:0] pad_input_mode_o,
   output logic [15:0] pad_output_mode_o,
   // monitor
   input wire logic link_up_i,
   input wire logic [15:0] sensor_data_i [8],
   output logic [2:0] sensor_sel_o,
   output logic sensor_reset_o,
   output logic monitor_busy_o
);
   import psm_pkg::*;
   logic [15:0] pin_r, pin_nxt, pout_r, pout_nxt;
   logic [15:0] c1_r, c1_nxt, c2_r, c2_nxt, c4_r, c4_nxt;
   logic [15:0] rd_r, rd_nxt;
   psm_strap_t sa_r, sa_nxt;
   logic sb_r, sb_nxt, cap_r, cap_nxt;
   logic [15:0] ps1_r, ps2_r, ps3_r, pstat_r, pstat_nxt;
   logic [15:0] plvl_r, plvl_nxt;
   logic [15:0] hist_r [HIST_DEPTH];
   logic [1:0] hptr_r, hptr_nxt;
   logic [2:0] hcnt_r, hcnt_nxt;
   logic go_r, go_nxt, brst_r, busy_r;
   logic [2:0] sel_r;
   logic store;
   logic [15:0] avg;
   logic seq_busy;
   psm_seq_cfg_t cfg;
   logic hold;
   logic [15:0] conv;
   logic [15:0] last_avg;
   assign cfg.div = c4_r[C4_DIV_LO+1:C4_DIV_LO];
   assign cfg.disc4 = c4_r[C4_DISC];
   assign cfg.avg4 = c4_r[C4_AVG];
   assign hold = c4_r[C4_RESET];
   // sampled sensor always follows the bypass select
   assign conv = sensor_data_i[c2_r[2:0]];
   assign last_avg = (hcnt_r == 3'h0) ? 16'h0000 : hist_r[hptr_r - 2'h1];
   psm_seq u_seq (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .hold_i(hold),
      .go_i(go_r),
      .periodic_i(c4_r[C4_PERIODIC]),
      .cfg_i(cfg),
      .sample_i(conv),
      .store_o(store),
      .avg_o(avg),
      .busy_o(seq_busy)
   );
   always_comb begin
      pin_nxt = pin_r;
      pout_nxt = pout_r;
      c1_nxt = c1_r;
      c2_nxt = c2_r;
      c4_nxt = c4_r;
      go_nxt = 1'b0;
      if (reg_wr_i) begin
         case (reg_addr_i)
            OFS_PAD_IN: pin_nxt = reg_wdata_i;
            OFS_PAD_OUT: pout_nxt = reg_wdata_i;
            OFS_MON_C1: c1_nxt = reg_wdata_i;
            OFS_MON_C2: c2_nxt = reg_wdata_i;
            OFS_MON_C4: c4_nxt = reg_wdata_i & MSK_MON_C4;
            default: ;
         endcase
      end
      // start pulses once and never reads back set
      if (reg_wr_i && reg_addr_i == OFS_MON_C4 && reg_wdata_i[C4_START] &&
          !reg_wdata_i[C4_RESET]) begin
         // link gate; force bypasses the link gate, a start without either is dropped
         go_nxt = link_up_i | reg_wdata_i[C4_FORCE];
      end
   end
   always_comb begin
      sa_nxt = sa_r;
      sb_nxt = sb_r;
      cap_nxt = 1'b1;
      if (!cap_r) begin
         sa_nxt = strap_a_i;
         sb_nxt = strap_managed_i;
      end
      // level accepted only once stages two and three agree
      plvl_nxt = (ps3_r & ~(ps2_r ^ ps3_r)) | (plvl_r & (ps2_r ^ ps3_r));
      pstat_nxt = pad_force_i ? plvl_r : 16'h0000;
   end
   always_comb begin
      hptr_nxt = hptr_r;
      hcnt_nxt = hcnt_r;
      if (c4_r[C4_HCLR]) begin
         hptr_nxt = 2'h0;
         hcnt_nxt = 3'h0;
      end else if (store) begin
         hptr_nxt = hptr_r + 2'h1;
         if (hcnt_r != 3'(HIST_DEPTH)) hcnt_nxt = hcnt_r + 3'h1;
      end
   end
   always_comb begin
      rd_nxt = rd_r;
      if (reg_rd_i) begin
         case (reg_addr_i)
            OFS_PAD_STAT: rd_nxt = pstat_r;
            OFS_PAD_IN: rd_nxt = pin_r;
            OFS_PAD_OUT: rd_nxt = pout_r;
            OFS_STRAP_A: rd_nxt = sa_r;
            OFS_STRAP_B: rd_nxt = {15'h0000, sb_r};
            OFS_REV: rd_nxt = {12'h000, REV_CODE};
            OFS_MON_C1: rd_nxt = c1_r;
            OFS_MON_C2: rd_nxt = c2_r;
            OFS_MON_C4: rd_nxt = c4_r;
            // debug select 0 gives last average, else raw sensor
            OFS_MON_ST: rd_nxt = (c2_r[14:12] == 3'h0) ? last_avg :
                                 sensor_data_i[c2_r[C2_RDSEL_LO+2:C2_RDSEL_LO]];
            default: rd_nxt = 16'h0000;
         endcase
      end
   end
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_r <= RST_PAD;
         pout_r <= RST_PAD;
         c1_r <= RST_MON_C1;
         c2_r <= RST_MON_C2;
         c4_r <= RST_MON_C4;
         go_r <= 1'b0;
         sa_r <= '0;
         sb_r <= 1'b0;
         cap_r <= 1'b0;
         ps1_r <= 16'h0000;
         ps2_r <= 16'h0000;
         ps3_r <= 16'h0000;
         pstat_r <= 16'h0000;
         hptr_r <= 2'h0;
         hcnt_r <= 3'h0;
         rd_r <= 16'h0000;
         sel_r <= 3'h0;
         brst_r <= 1'b0;
         plvl_r <= 16'h0000;
         busy_r <= 1'b0;
      end else begin
         pin_r <= pin_nxt;
         pout_r <= pout_nxt;
         c1_r <= c1_nxt;
         c2_r <= c2_nxt;
         c4_r <= c4_nxt;
         go_r <= go_nxt;
         sa_r <= sa_nxt;
         sb_r <= sb_nxt;
         cap_r <= cap_nxt;
         ps1_r <= pad_level_i;
         ps2_r <= ps1_r;
         ps3_r <= ps2_r;
         plvl_r <= plvl_nxt;
         pstat_r <= pstat_nxt;
         hptr_r <= hptr_nxt;
         hcnt_r <= hcnt_nxt;
         rd_r <= rd_nxt;
         sel_r <= c2_r[2:0];
         brst_r <= hold | c2_r[C2_BYP_RST];
         busy_r <= seq_busy;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (store && !c4_r[C4_HCLR]) hist_r[hptr_r] <= avg;
   end
   assign reg_rdata_o = rd_r;
   assign pad_input_mode_o = pin_r;
   assign pad_output_mode_o = pout_r;
   assign sensor_sel_o = sel_r;
   assign sensor_reset_o = brst_r;
   assign monitor_busy_o = busy_r;
endmodule

// file: src/psm_pkg.sv
package psm_pkg;
   localparam logic [10:0] OFS_PAD_IN = 11'h459;
   localparam logic [10:0] OFS_PAD_OUT = 11'h45A;
   localparam logic [10:0] OFS_PAD_STAT = 11'h457;
   localparam logic [10:0] OFS_STRAP_A = 11'h45D;
   localparam logic [10:0] OFS_STRAP_B = 11'h45E;
   localparam logic [10:0] OFS_REV = 11'h466;
   localparam logic [10:0] OFS_MON_C1 = 11'h467;
   localparam logic [10:0] OFS_MON_C2 = 11'h468;
   localparam logic [10:0] OFS_MON_C4 = 11'h46A;
   localparam logic [10:0] OFS_MON_ST = 11'h47B;
   localparam logic [15:0] RST_PAD = 16'h0000;
   localparam logic [15:0] RST_MON_C1 = 16'h0012;
   localparam logic [15:0] RST_MON_C2 = 16'h0920;
   localparam logic [15:0] RST_MON_C4 = 16'h0094;
   localparam logic [15:0] MSK_MON_C4 = 16'h01FE;
   localparam int C4_START = 0;
   localparam int C4_PERIODIC = 1;
   localparam int C4_RESET = 2;
   localparam int C4_FORCE = 3;
   localparam int C4_DIV_LO = 4;
   localparam int C4_AVG = 6;
   localparam int C4_DISC = 7;
   localparam int C4_HCLR = 8;
   localparam int C2_BYP_RST = 15;
   localparam int C2_RDSEL_LO = 12;
   // clock ticks per converter sample for div codes 0..2
   localparam logic [3:0] DIV_TICKS0 = 4'h1;
   localparam logic [3:0] DIV_TICKS1 = 4'h2;
   localparam logic [3:0] DIV_TICKS2 = 4'h4;
   localparam logic [2:0] DISC_LO = 3'h2;
   localparam logic [2:0] DISC_HI = 3'h4;
   localparam logic [2:0] AVG_LO = 3'h2;
   localparam logic [2:0] AVG_HI = 3'h4;
   localparam int HIST_DEPTH = 4;
   typedef struct packed {
      logic [1:0] div;
      logic disc4;
      logic avg4;
   } psm_seq_cfg_t;
   typedef struct packed {
      logic tx_shift;
      logic rx_shift;
      logic sgmii_en;
      logic rgmii_en;
      logic [2:0] test_mode;
      logic [2:0] mac_mode;
      logic role;
      logic [4:0] addr;
   } psm_strap_t;
   typedef enum logic [3:0] {
      SQ_IDLE = 4'h1,
      SQ_DISC = 4'h2,
      SQ_AVG = 4'h4,
      SQ_STORE = 4'h8
   } psm_seq_state_t;
endpackage

// file: src/psm_seq.sv
`timescale 1ns/1ps
module psm_seq
   import psm_pkg::*;
(
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // control
   input wire logic hold_i,
   input wire logic go_i,
   input wire logic periodic_i,
   input wire psm_seq_cfg_t cfg_i,
   // converter
   input wire logic [15:0] sample_i,
   // result
   output logic store_o,
   output logic [15:0] avg_o,
   output logic busy_o
);
   psm_seq_state_t st_r, st_nxt;
   logic [3:0] tick_r, tick_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [17:0] acc_r, acc_nxt;
   logic [3:0] ticks;
   logic samp;
   always_comb begin
      case (cfg_i.div)
         2'b00: ticks = DIV_TICKS0;
         2'b01: ticks = DIV_TICKS1;
         default: ticks = DIV_TICKS2; // reserved code runs slowest
      endcase
   end
   assign samp = (tick_r >= ticks - 4'h1);
   always_comb begin
      st_nxt = st_r;
      tick_nxt = samp ? 4'h0 : tick_r + 4'h1;
      cnt_nxt = cnt_r;
      acc_nxt = acc_r;
      store_o = 1'b0;
      case (st_r)
         SQ_IDLE: begin
            tick_nxt = 4'h0;
            if (go_i) begin
               st_nxt = SQ_DISC;
               cnt_nxt = 3'h0;
            end
         end
         SQ_DISC: begin
            if (samp) begin
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r + 3'h1 == (cfg_i.disc4 ? DISC_HI : DISC_LO)) begin
                  st_nxt = SQ_AVG;
                  cnt_nxt = 3'h0;
                  acc_nxt = 18'h0;
               end
            end
         end
         SQ_AVG: begin
            if (samp) begin
               acc_nxt = acc_r + {2'b00, sample_i};
               cnt_nxt = cnt_r + 3'h1;
               if (cnt_r + 3'h1 == (cfg_i.avg4 ? AVG_HI : AVG_LO)) begin
                  st_nxt = SQ_STORE;
               end
            end
         end
         SQ_STORE: begin
            store_o = 1'b1;
            cnt_nxt = 3'h0;
            st_nxt = periodic_i ? SQ_DISC : SQ_IDLE;
         end
         default: st_nxt = SQ_IDLE;
      endcase
      if (hold_i) begin
         st_nxt = SQ_IDLE;
         store_o = 1'b0;
      end
   end
   assign avg_o = cfg_i.avg4 ? acc_r[17:2] : acc_r[16:1];
   assign busy_o = (st_r != SQ_IDLE);
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r <= SQ_IDLE;
         tick_r <= 4'h0;
         cnt_r <= 3'h0;
         acc_r <= 18'h0;
      end else begin
         st_r <= st_nxt;
         tick_r <= tick_nxt;
         cnt_r <= cnt_nxt;
         acc_r <= acc_nxt;
      end
   end
endmodule

// file: tb/psm_sensor_model.sv
`timescale 1ns/1ps
module psm_sensor_model (
   // sensor control from the block
   input wire logic [2:0] sel_i,
   input wire logic rst_i,
   // converter outputs
   output logic [15:0] data_o [8]
);
   // a sensor held in reset reads zero, never its old value
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         data_o[k] = (rst_i && sel_i == k[2:0]) ? 16'h0000 : 16'h0A00 + k[15:0];
      end
   end
endmodule

// file: tb/psm_regs_properties.sv
`timescale 1ns/1ps
module psm_chk
   import psm_pkg::*;
#(
   parameter logic [3:0] REV_CODE = 4'h3
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [10:0] reg_addr_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire psm_strap_t strap_a_i,
   input wire logic [15:0] pad_input_mode_o,
   input wire logic link_up_i,
   input wire logic [2:0] sensor_sel_o,
   input wire logic sensor_reset_o,
   input wire logic monitor_busy_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   logic w2;
   logic w4;
   assign w2 = reg_wr_i && reg_addr_i == OFS_MON_C2;
   assign w4 = reg_wr_i && reg_addr_i == OFS_MON_C4;
   AST_PAD_IN: assert property ((reg_wr_i && reg_addr_i == OFS_PAD_IN) |->
      ##2 pad_input_mode_o == $past(reg_wdata_i, 2)) else $error("pad input mode");
   AST_SEL: assert property (w2 |-> ##2 sensor_sel_o == $past(reg_wdata_i[2:0], 2))
      else $error("sensor select");
   AST_SRST: assert property ((w4 && reg_wdata_i[C4_RESET]) || (w2 && reg_wdata_i[15])
      |-> ##2 sensor_reset_o) else $error("sensor reset");
   AST_ABORT: assert property (w4 && reg_wdata_i[C4_RESET] |-> ##[1:3] !monitor_busy_o)
      else $error("abort");
   AST_GO: assert property (w4 && reg_wdata_i[0] && !reg_wdata_i[2] && !monitor_busy_o &&
      (reg_wdata_i[3] || link_up_i) |-> ##[2:4] monitor_busy_o) else $error("start");
   AST_STRAP: assert property (reg_rd_i && reg_addr_i == OFS_STRAP_A |=>
      reg_rdata_o == $past(strap_a_i)) else $error("strap read");
   AST_REV: assert property (reg_rd_i && reg_addr_i == OFS_REV |=>
      reg_rdata_o == {12'h000, REV_CODE}) else $error("revision read");
   AST_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("rdata hold");
endmodule

bind psm_regs psm_chk #(.REV_CODE(REV_CODE)) chk_i (.mclk_i, .rst_b_i, .reg_wr_i, .reg_rd_i,
   .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .strap_a_i, .pad_input_mode_o, .link_up_i,
   .sensor_sel_o, .sensor_reset_o, .monitor_busy_o);

// file: tb/psm_regs_tb.sv
`timescale 1ns/1ps
module psm_regs_tb;
   import psm_pkg::*;
   logic mclk_i, rst_b_i, reg_wr_i, reg_rd_i, strap_managed_i, pad_force_i, link_up_i;
   logic [10:0] reg_addr_i;
   logic [15:0] reg_wdata_i, reg_rdata_o, pad_level_i, pad_input_mode_o, pad_output_mode_o, v;
   logic [15:0] sensor_data_i [8];
   psm_strap_t strap_a_i;
   logic [2:0] sensor_sel_o;
   logic sensor_reset_o, monitor_busy_o;
   int errors, n_checks, len, l0;
   psm_regs dut (.mclk_i, .rst_b_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i,
      .reg_rdata_o, .strap_a_i, .strap_managed_i, .pad_level_i, .pad_force_i,
      .pad_input_mode_o, .pad_output_mode_o, .link_up_i, .sensor_data_i, .sensor_sel_o,
      .sensor_reset_o, .monitor_busy_o);
   psm_sensor_model sm (.sel_i(sensor_sel_o), .rst_i(sensor_reset_o), .data_o(sensor_data_i));
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic timeout;
      errors++;
      tally_and_finish();
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("Error t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i) #1;
   endtask
   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      cyc(1);
      reg_wr_i = 1'b0;
      cyc(1);
   endtask
   task automatic rd(input logic [10:0] a);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      cyc(1);
      reg_rd_i = 1'b0;
      cyc(1);
      v = reg_rdata_o;
   endtask
   task automatic do_reset;
      rst_b_i = 1'b0;
      cyc(2);
      rst_b_i = 1'b1;
      cyc(1);
   endtask
   task automatic run(input logic [15:0] c);
      int k;
      wr(OFS_MON_C4, c);
      for (k = 0; monitor_busy_o !== 1'b1; k++) begin
         if (k > 9) timeout();
         cyc(1);
      end
      for (len = 0; monitor_busy_o === 1'b1; len++) begin
         if (len > 300) timeout();
         cyc(1);
      end
   endtask
   task automatic t_straps;
      logic [2:0] mc [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
      logic [4:0] ad [9] = '{5'h0, 5'h4, 5'h5, 5'h8, 5'hA, 5'hC, 5'hD, 5'hE, 5'hF};
      for (int i = 0; i < 9; i++) begin
         strap_a_i = {i[0], ~i[0], i[1], ~i[1], 3'h0, mc[i % 5], i[2], ad[i]};
         strap_managed_i = i[0];
         do_reset();
         rd(OFS_STRAP_A);
         chk(v, strap_a_i);
         rd(OFS_STRAP_B);
         chk(v, {15'h0, i[0]});
      end
      $display("straps done");
   endtask
   task automatic t_regs;
      logic [10:0] a [8] = '{OFS_PAD_IN, OFS_PAD_OUT, OFS_REV, OFS_MON_C1, OFS_MON_C2,
         OFS_MON_C4, OFS_PAD_STAT, 11'h000};
      logic [15:0] e [8] = '{RST_PAD, RST_PAD, 16'h0003, RST_MON_C1, RST_MON_C2,
         RST_MON_C4, 16'h0000, 16'h0000};
      do_reset();
      for (int i = 0; i < 8; i++) begin
         rd(a[i]);
         chk(v, e[i]);
      end
      wr(OFS_PAD_IN, 16'hA5C3);
      wr(OFS_PAD_OUT, 16'h5A3C);
      wr(OFS_STRAP_A, 16'hFFFF);
      chk(pad_input_mode_o, 16'hA5C3);
      chk(pad_output_mode_o, 16'h5A3C);
      rd(OFS_PAD_OUT);
      chk(v, 16'h5A3C);
      rd(OFS_STRAP_A);
      chk(v, strap_a_i);
      pad_force_i = 1'b1;
      cyc(4);
      rd(OFS_PAD_STAT);
      chk(v, 16'h1234);
      pad_level_i = 16'hABCD;
      cyc(6);
      rd(OFS_PAD_STAT);
      chk(v, 16'hABCD);
      $display("registers done");
   endtask
   task automatic t_mon;
      wr(OFS_MON_C2, 16'h0003);
      chk({13'h0, sensor_sel_o}, 16'h0003);
      wr(OFS_MON_C4, 16'h0001);
      cyc(5);
      chk({15'h0, monitor_busy_o}, 16'h0000);
      run(16'h0009);
      l0 = len;
      cyc(5);
      chk({15'h0, monitor_busy_o}, 16'h0000);
      run(16'h0089);
      chk(16'(len), 16'(l0 + 2));
      run(16'h0049);
      chk(16'(len), 16'(l0 + 2));
      run(16'h0019);
      chk(16'(len), 16'(l0 + 4));
      run(16'h0029);
      chk(16'(len), 16'(l0 + 12));
      rd(OFS_MON_C4);
      chk(v, 16'h0028);
      rd(OFS_MON_ST);
      chk(v, 16'h0A03);
      link_up_i = 1'b1;
      run(16'h0001);
      chk(16'(len), 16'(l0));
      wr(OFS_MON_C4, 16'h0003);
      len = 0;
      repeat (100) begin
         cyc(1);
         if (monitor_busy_o === 1'b1) len++;
      end
      chk(16'(len > 80), 16'h0001);
      wr(OFS_MON_C4, 16'h0004);
      cyc(1);
      chk({14'h0, monitor_busy_o, sensor_reset_o}, 16'h0001);
      wr(OFS_MON_C4, 16'h0100);
      rd(OFS_MON_ST);
      chk(v, 16'h0000);
      chk({15'h0, sensor_reset_o}, 16'h0000);
      wr(OFS_MON_C2, 16'hD003);
      rd(OFS_MON_ST);
      chk(v, 16'h0A05);
      chk({15'h0, sensor_reset_o}, 16'h0001);
      $display("monitor done");
   endtask
   initial begin
      rst_b_i = 1'b0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 11'h000;
      reg_wdata_i = 16'h0000;
      strap_a_i = 16'h0000;
      strap_managed_i = 1'b0;
      pad_level_i = 16'h1234;
      pad_force_i = 1'b0;
      link_up_i = 1'b0;
      errors = 0;
      n_checks = 0;
      cyc(1);
      t_straps();
      t_regs();
      t_mon();
      tally_and_finish();
   end
endmodule
